/* rtl/clock_control_pkg.sv */
// Constants shared by the clock source selection and start-up controller
package clock_control_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] CAL_OFFSET     = 8'h08;
  localparam logic [7:0] STORE_OFFSET   = 8'h10;
  localparam logic [7:0] STORE_MASK     = 8'hf3;

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_SLEEP_BIT  = 2;
  localparam int CTRL_ASYNC_BIT  = 3;

  // Sleep modes
  localparam logic [1:0] MODE_IDLE       = 2'h0;
  localparam logic [1:0] MODE_ADC_QUIET  = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
  localparam logic [1:0] MODE_POWER_SAVE = 2'h3;

  // ---------------------------------------------------------------------
  // Fuse values and decode boundaries
  // ---------------------------------------------------------------------
  localparam logic [3:0] DELIVERED_SOURCE   = 4'h1;
  localparam logic [1:0] DELIVERED_STARTUP  = 2'h2;
  localparam logic       DELIVERED_AMP      = 1'h1;
  localparam logic [3:0] CRYSTAL_LOW_CODE   = 4'ha;
  localparam logic [3:0] LOW_FREQ_CODE      = 4'h9;
  localparam logic [3:0] EXT_RC_LOW_CODE    = 4'h5;
  localparam logic [3:0] INT_RC_LOW_CODE    = 4'h1;
  localparam logic [2:0] BAND_LOW_CODE      = 3'h5;
  localparam logic [2:0] BAND_MID_CODE      = 3'h6;
  localparam logic [2:0] BAND_HIGH_CODE     = 3'h7;

  // Clock source classes
  typedef enum logic [2:0] {
    SRC_EXT_CLOCK, SRC_INT_RC, SRC_EXT_RC, SRC_LOW_FREQ, SRC_CRYSTAL
  } source_e;

  // Reset delay choices
  localparam logic [1:0] WDT_NONE  = 2'h0;
  localparam logic [1:0] WDT_SHORT = 2'h1;
  localparam logic [1:0] WDT_LONG  = 2'h2;

  // ---------------------------------------------------------------------
  // Timing counts (cycles of the source or of the watchdog oscillator)
  // ---------------------------------------------------------------------
  localparam int CNT_W              = 17;
  localparam logic [16:0] CK_6      = 17'h00006;
  localparam logic [16:0] CK_18     = 17'h00012;
  localparam logic [16:0] CK_258    = 17'h00102;
  localparam logic [16:0] CK_1K     = 17'h00400;
  localparam int          CK_16K    = 16384;
  localparam int          CK_32K    = 32768;
  localparam logic [16:0] WDT_SHORT_CYCLES = 17'h01000;
  localparam int          WDT_LONG_CYCLES  = 65536;

  // Calibration store
  localparam int          CAL_ENTRIES = 4;
  localparam logic [7:0]  CAL_DEFAULT = 8'h80;

endpackage

/* rtl/calibration_store.sv */
// Small calibration byte store, one byte per internal oscillator frequency
`timescale 1ns/1ps
module calibration_store (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read port, data registered
  input  wire logic [1:0] rd_addr,
  output logic      [7:0] rd_data
);
  import clock_control_pkg::*;

  logic [7:0] entry_q [CAL_ENTRIES];

  genvar i;
  generate
    for (i = 0; i < CAL_ENTRIES; i++) begin : g_entry
      // Entries survive reset, since start-up on the internal RC reloads entry 0 from here
      always_ff @(posedge ref_clk) begin
        if (wr_en && wr_addr == 2'(i)) begin
          entry_q[i] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= CAL_DEFAULT;
    end else begin
      rd_data <= entry_q[rd_addr];
    end
  end

endmodule

/* rtl/clock_source_select_startup.sv */
// Clock source decode, start-up timing and domain clock enables
`timescale 1ns/1ps
module clock_source_select_startup #(
  parameter int LONG_WDT_CYCLES = clock_control_pkg::WDT_LONG_CYCLES,
  parameter int SRC_16K_CYCLES  = clock_control_pkg::CK_16K,
  parameter int SRC_32K_CYCLES  = clock_control_pkg::CK_32K
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fuses and oscillator inputs (asynchronous)
  input  wire logic [3:0]  clock_source_fuses,
  input  wire logic [1:0]  startup_time_fuses,
  input  wire logic        amplifier_option_fuse,
  input  wire logic        osc_in_pin,
  input  wire logic        internal_rc_osc,
  input  wire logic        watchdog_osc,
  input  wire logic        wake_req,
  // Domain clock enables
  output logic             core_clock_en,
  output logic             peripheral_clock_en,
  output logic             program_memory_clock_en,
  output logic             converter_clock_en,
  output logic             async_timer_clock_en,
  output logic             async_detect_en,
  // Oscillator configuration
  output logic             amp_full_swing,
  output logic [1:0]       crystal_band,
  output clock_control_pkg::source_e source_class,
  output logic [7:0]       rc_calibration_register,
  output logic             startup_done
);
  import clock_control_pkg::*;

  typedef enum logic [2:0] {
    ST_CAPTURE, ST_CAL_LOAD, ST_SRC_COUNT, ST_WDT_COUNT, ST_RUN, ST_SLEEP
  } state_e;

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------
  logic [3:0] src_meta_q, src_sync_q;
  logic [1:0] sut_meta_q, sut_sync_q;
  logic       amp_meta_q, amp_sync_q;
  logic [3:0] osc_meta_q, osc_sync_q, osc_last_q;

  // No reset here, so fuses set during reset are through by the capture cycle
  // Oscillators and wake request: bit 0 crystal pin, 1 RC, 2 watchdog, 3 wake
  always_ff @(posedge ref_clk) begin
    src_meta_q <= clock_source_fuses;
    src_sync_q <= src_meta_q;
    sut_meta_q <= startup_time_fuses;
    sut_sync_q <= sut_meta_q;
    amp_meta_q <= amplifier_option_fuse;
    amp_sync_q <= amp_meta_q;
    osc_meta_q <= {wake_req, watchdog_osc, internal_rc_osc, osc_in_pin};
    osc_sync_q <= osc_meta_q;
    osc_last_q <= osc_sync_q;
  end

  wire [3:0] osc_rise = osc_sync_q & ~osc_last_q;

  // ---------------------------------------------------------------------
  // Fuse decode, captured once per reset
  // ---------------------------------------------------------------------
  logic [3:0] src_cfg_q;
  logic [1:0] sut_cfg_q;
  logic       amp_cfg_q;

  // A fuse at one is unprogrammed, so the option is active when zero
  wire amp_programmed = ~amp_cfg_q;

  wire source_e cls_w = (src_cfg_q >= CRYSTAL_LOW_CODE) ? SRC_CRYSTAL :
                        (src_cfg_q == LOW_FREQ_CODE)    ? SRC_LOW_FREQ :
                        (src_cfg_q >= EXT_RC_LOW_CODE)  ? SRC_EXT_RC :
                        (src_cfg_q >= INT_RC_LOW_CODE)  ? SRC_INT_RC :
                                                          SRC_EXT_CLOCK;

  // Band 0 means the wide range of the full-swing amplifier
  wire [1:0] band_w = (cls_w != SRC_CRYSTAL || amp_programmed) ? 2'h0 :
                      (src_cfg_q[3:1] == BAND_LOW_CODE)  ? 2'h1 :
                      (src_cfg_q[3:1] == BAND_MID_CODE)  ? 2'h2 :
                      (src_cfg_q[3:1] == BAND_HIGH_CODE) ? 2'h3 : 2'h0;

  // ---------------------------------------------------------------------
  // Start-up table
  // ---------------------------------------------------------------------
  localparam logic [16:0] CK_16K_W  = 17'(SRC_16K_CYCLES);
  localparam logic [16:0] CK_32K_W  = 17'(SRC_32K_CYCLES);
  localparam logic [16:0] WDT_LONG_W = 17'(LONG_WDT_CYCLES);

  logic [16:0] src_target;
  logic [1:0]  wdt_choice;

  always_comb begin
    src_target = CK_6;
    wdt_choice = WDT_LONG;
    case (cls_w)
      SRC_CRYSTAL: begin
        case ({src_cfg_q[0], sut_cfg_q})
          3'h0: begin src_target = CK_258;   wdt_choice = WDT_SHORT; end
          3'h1: begin src_target = CK_258;   wdt_choice = WDT_LONG;  end
          3'h2: begin src_target = CK_1K;    wdt_choice = WDT_NONE;  end
          3'h3: begin src_target = CK_1K;    wdt_choice = WDT_SHORT; end
          3'h4: begin src_target = CK_1K;    wdt_choice = WDT_LONG;  end
          3'h5: begin src_target = CK_16K_W; wdt_choice = WDT_NONE;  end
          3'h6: begin src_target = CK_16K_W; wdt_choice = WDT_SHORT; end
          default: begin src_target = CK_16K_W; wdt_choice = WDT_LONG; end
        endcase
      end
      SRC_LOW_FREQ: begin
        src_target = (sut_cfg_q[1]) ? CK_32K_W : CK_1K;
        wdt_choice = (sut_cfg_q == 2'h0) ? WDT_SHORT : WDT_LONG;
      end
      SRC_EXT_RC: begin
        src_target = (sut_cfg_q == 2'h3) ? CK_6 : CK_18;
        wdt_choice = (sut_cfg_q == 2'h0) ? WDT_NONE :
                     (sut_cfg_q == 2'h2) ? WDT_LONG : WDT_SHORT;
      end
      default: begin
        src_target = CK_6;
        wdt_choice = (sut_cfg_q == 2'h0) ? WDT_NONE :
                     (sut_cfg_q == 2'h1) ? WDT_SHORT : WDT_LONG;
      end
    endcase
  end

  wire [16:0] wdt_target = (wdt_choice == WDT_SHORT) ? WDT_SHORT_CYCLES : WDT_LONG_W;

  // The selected source times the start-up, not the system clock itself
  wire src_tick = (cls_w == SRC_INT_RC) ? osc_rise[1] : osc_rise[0];
  wire wdt_tick = osc_rise[2];
  wire wake_lvl = osc_sync_q[3];

  // ---------------------------------------------------------------------
  // APB slave: one wait state, so the store's registered data is ready
  // ---------------------------------------------------------------------
  logic        pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0]  ctrl_q;
  logic [7:0]  cal_q;

  wire         access     = psel & penable;
  wire         pready_d   = access & ~pready_q;
  wire         done       = access & pready_q;
  wire         hit_ctrl   = (paddr == CTRL_OFFSET);
  wire         hit_status = (paddr == STATUS_OFFSET);
  wire         hit_cal    = (paddr == CAL_OFFSET);
  wire         hit_store  = ((paddr & STORE_MASK) == STORE_OFFSET);
  wire         mapped     = hit_ctrl | hit_status | hit_cal | hit_store;
  wire         wr_done    = done & pwrite & mapped;
  wire         wr_ctrl    = wr_done & hit_ctrl;
  wire         wr_cal     = wr_done & hit_cal;
  wire         wr_store   = wr_done & hit_store;
  wire         sleep_go   = wr_ctrl & pwdata[CTRL_SLEEP_BIT];

  // ---------------------------------------------------------------------
  // Calibration store
  // ---------------------------------------------------------------------
  state_e     state_q, state_d;
  logic [7:0] store_rd;

  // During capture the store is pointed at the 1 MHz entry
  wire [1:0] store_rd_addr = (state_q == ST_CAPTURE) ? 2'h0 : paddr[3:2];

  calibration_store u_store (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_store),
    .wr_addr (paddr[3:2]),
    .wr_data (pwdata[7:0]),
    .rd_addr (store_rd_addr),
    .rd_data (store_rd)
  );

  // ---------------------------------------------------------------------
  // Start-up sequencer
  // ---------------------------------------------------------------------
  logic [16:0] cnt_q, cnt_d;
  logic        from_reset_q;
  logic [1:0]  mode_q;

  wire deep_sleep = (mode_q == MODE_POWER_DOWN) || (mode_q == MODE_POWER_SAVE);
  wire src_last   = src_tick && (cnt_q == src_target - 17'h1);
  wire wdt_last   = wdt_tick && (cnt_q == wdt_target - 17'h1);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_CAPTURE: state_d = ST_CAL_LOAD;
      ST_CAL_LOAD: begin
        state_d = ST_SRC_COUNT;
        cnt_d   = 17'h0;
      end
      ST_SRC_COUNT: begin
        if (src_last) begin
          cnt_d   = 17'h0;
          state_d = (from_reset_q && wdt_choice != WDT_NONE) ? ST_WDT_COUNT : ST_RUN;
        end else if (src_tick) begin
          cnt_d = cnt_q + 17'h1;
        end
      end
      ST_WDT_COUNT: begin
        if (wdt_last) begin
          state_d = ST_RUN;
        end else if (wdt_tick) begin
          cnt_d = cnt_q + 17'h1;
        end
      end
      ST_RUN: state_d = sleep_go ? ST_SLEEP : ST_RUN;
      ST_SLEEP: begin
        if (wake_lvl) begin
          cnt_d   = 17'h0;
          state_d = deep_sleep ? ST_SRC_COUNT : ST_RUN;
        end
      end
      default: state_d = ST_CAPTURE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_CAPTURE;
      cnt_q   <= 17'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Fuses are sampled once after reset; later changes wait for the next reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_cfg_q    <= DELIVERED_SOURCE;
      sut_cfg_q    <= DELIVERED_STARTUP;
      amp_cfg_q    <= DELIVERED_AMP;
      from_reset_q <= 1'b1;
    end else begin
      if (state_q == ST_CAPTURE) begin
        src_cfg_q <= src_sync_q;
        sut_cfg_q <= sut_sync_q;
        amp_cfg_q <= amp_sync_q;
      end
      if (state_q == ST_SLEEP) begin
        from_reset_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Control, calibration and bus registers
  // ---------------------------------------------------------------------
  wire in_reset_seq = (state_q != ST_RUN) && (state_q != ST_SLEEP) && from_reset_q;
  wire [3:0] ctrl_d = wr_ctrl ? {pwdata[CTRL_ASYNC_BIT], 1'b0, pwdata[1:0]} : ctrl_q;
  wire [7:0] cal_d  = (state_q == ST_CAL_LOAD && cls_w == SRC_INT_RC) ? store_rd :
                      wr_cal ? pwdata[7:0] : cal_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= 4'h0;
      cal_q  <= CAL_DEFAULT;
      mode_q <= MODE_IDLE;
    end else begin
      ctrl_q <= ctrl_d;
      cal_q  <= cal_d;
      if (sleep_go && state_q == ST_RUN) begin
        mode_q <= pwdata[1:0];
      end
    end
  end

  wire [31:0] status_w = {22'h0, state_q == ST_RUN, in_reset_seq, amp_programmed,
                          band_w, 1'b0, cls_w, src_cfg_q == 4'h0 ? 1'b0 : 1'b1};
  wire [31:0] rdata_w  = hit_ctrl   ? {28'h0, ctrl_q} :
                         hit_status ? status_w :
                         hit_cal    ? {24'h0, cal_q} :
                         hit_store  ? {24'h0, store_rd} : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pready_d & ~mapped;
      prdata_q  <= (pready_d & ~pwrite) ? rdata_w : 32'h0;
    end
  end

  // ---------------------------------------------------------------------
  // Domain clock enables
  // ---------------------------------------------------------------------
  wire running  = (state_q == ST_RUN);
  wire sleeping = (state_q == ST_SLEEP);

  // Core and program memory stop together; the core is idle while halted
  wire core_d  = running;
  wire flash_d = running;
  wire io_d    = running | (sleeping & mode_q == MODE_IDLE);
  wire adc_d   = running | (sleeping & (mode_q == MODE_IDLE | mode_q == MODE_ADC_QUIET));
  // Timer crystal shares the oscillator pins, so it needs the internal RC
  wire async_ok = ctrl_q[CTRL_ASYNC_BIT] & (cls_w == SRC_INT_RC);
  wire async_d  = async_ok & ~(sleeping & mode_q == MODE_POWER_DOWN);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_clock_en           <= 1'b0;
      program_memory_clock_en <= 1'b0;
      peripheral_clock_en     <= 1'b0;
      converter_clock_en      <= 1'b0;
      async_timer_clock_en    <= 1'b0;
      async_detect_en         <= 1'b0;
      startup_done            <= 1'b0;
      amp_full_swing          <= 1'b0;
      crystal_band            <= 2'h0;
      source_class            <= SRC_INT_RC;
    end else begin
      core_clock_en           <= core_d;
      program_memory_clock_en <= flash_d;
      peripheral_clock_en     <= io_d;
      converter_clock_en      <= adc_d;
      async_timer_clock_en    <= async_d;
      async_detect_en         <= ~io_d;
      startup_done            <= running | sleeping;
      amp_full_swing          <= amp_programmed;
      crystal_band            <= band_w;
      source_class            <= cls_w;
    end
  end

  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign rc_calibration_register = cal_q;

endmodule

/* verification/clock_startup_checker.sv */
// Concurrent checks on the clock source and start-up controller ports
`timescale 1ns/1ps
module clock_startup_checker
  import clock_control_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Fuses
  input wire logic [3:0] clock_source_fuses,
  input wire logic       amplifier_option_fuse,
  // Observed outputs
  input wire logic       core_clock_en,
  input wire logic       peripheral_clock_en,
  input wire logic       program_memory_clock_en,
  input wire logic       converter_clock_en,
  input wire logic       async_timer_clock_en,
  input wire logic       async_detect_en,
  input wire logic       amp_full_swing,
  input wire logic [1:0] crystal_band,
  input wire source_e    source_class,
  input wire logic       startup_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Expected decode
  // ---------------------------------------------------------------
  // Fuses only move while reset is high, so the live pins equal the captured copy
  source_e    cls_exp;
  logic [1:0] band_exp;
  logic       any_en;
  assign cls_exp  = (clock_source_fuses >= CRYSTAL_LOW_CODE) ? SRC_CRYSTAL :
                    (clock_source_fuses == LOW_FREQ_CODE) ? SRC_LOW_FREQ :
                    (clock_source_fuses >= EXT_RC_LOW_CODE) ? SRC_EXT_RC :
                    (clock_source_fuses >= INT_RC_LOW_CODE) ? SRC_INT_RC : SRC_EXT_CLOCK;
  assign band_exp = (cls_exp == SRC_CRYSTAL && amplifier_option_fuse) ? 2'(clock_source_fuses[3:1] - 3'h4) : 2'h0;
  assign any_en   = core_clock_en | peripheral_clock_en | converter_clock_en | program_memory_clock_en;

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_class; startup_done |-> source_class == cls_exp; endproperty
  a_class: assert property (p_class) else $error("source class decode wrong");
  property p_band; startup_done |-> crystal_band == band_exp; endproperty
  a_band: assert property (p_band) else $error("crystal band wrong");
  property p_amp; startup_done |-> amp_full_swing == !amplifier_option_fuse; endproperty
  a_amp: assert property (p_amp) else $error("amplifier mode wrong");
  property p_pmem; core_clock_en == program_memory_clock_en; endproperty
  a_pmem: assert property (p_pmem) else $error("program memory clock differs from core");
  property p_hold; any_en |-> startup_done; endproperty
  a_hold: assert property (p_hold) else $error("domain clock before start-up end");
  property p_together; $rose(core_clock_en) |-> peripheral_clock_en && converter_clock_en && startup_done; endproperty
  a_together: assert property (p_together) else $error("domains not released together");
  property p_conv; peripheral_clock_en |-> converter_clock_en; endproperty
  a_conv: assert property (p_conv) else $error("converter clock off while peripheral on");
  property p_detect; $fell(peripheral_clock_en) |-> async_detect_en && !core_clock_en; endproperty
  a_detect: assert property (p_detect) else $error("async detect not on when peripheral halts");
  property p_async; async_timer_clock_en |-> source_class == SRC_INT_RC; endproperty
  a_async: assert property (p_async) else $error("async timer without internal oscillator");
  property p_wait; $fell(rst) |-> !startup_done [*8]; endproperty
  a_wait: assert property (p_wait) else $error("start-up ended without counting");

  c_release: cover property ($rose(core_clock_en));
  c_detect: cover property (async_detect_en);
  c_async_sleep: cover property (async_timer_clock_en && !core_clock_en);
endmodule

bind clock_source_select_startup clock_startup_checker chk_i (
  .ref_clk(ref_clk), .rst(rst), .clock_source_fuses(clock_source_fuses),
  .amplifier_option_fuse(amplifier_option_fuse), .core_clock_en(core_clock_en),
  .peripheral_clock_en(peripheral_clock_en), .program_memory_clock_en(program_memory_clock_en),
  .converter_clock_en(converter_clock_en), .async_timer_clock_en(async_timer_clock_en),
  .async_detect_en(async_detect_en), .amp_full_swing(amp_full_swing), .crystal_band(crystal_band),
  .source_class(source_class), .startup_done(startup_done)
);

/* verification/osc_sources.sv */
// Free-running oscillator sources seen by the start-up controller
`timescale 1ns/1ps
module osc_sources #(
  parameter int XTAL_HALF = 20,
  parameter int RC_HALF   = 40,
  parameter int WDT_HALF  = 30
) (
  // Oscillator outputs
  output logic osc_in_pin,
  output logic internal_rc_osc,
  output logic watchdog_osc
);
  // Odd start offsets keep every source out of phase with the system clock
  initial begin
    osc_in_pin = 1'b0;
    #3;
    forever #(XTAL_HALF) osc_in_pin = ~osc_in_pin;
  end
  initial begin
    internal_rc_osc = 1'b0;
    #7;
    forever #(RC_HALF) internal_rc_osc = ~internal_rc_osc;
  end
  initial begin
    watchdog_osc = 1'b0;
    #11;
    forever #(WDT_HALF) watchdog_osc = ~watchdog_osc;
  end
endmodule

/* verification/clock_source_select_startup_bench.sv */
// Self-checking bench for the clock source and start-up controller
`timescale 1ns/1ps
module clock_source_select_startup_bench;
  import clock_control_pkg::*;
  typedef struct {logic [3:0] f; logic [1:0] s; logic a; int ns; int ps; int nw; source_e c;} case_s;
  logic        ref_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, amp_f = 1'b1, wake_req = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, osc_in, rc_osc, wdt_osc;
  logic [3:0]  src_f = 4'h1;
  logic [1:0]  sut_f = 2'h2, band;
  logic        core_en, per_en, pm_en, cv_en, at_en, det_en, amp_fs, done;
  source_e     cls;
  logic [7:0]  cal;
  int          err_total = 0, check_count = 0, n;
  // Source edges with counts shortened to 8 and long watchdog delay to 16
  case_s       tbl[9] = '{'{4'h1, 2'h2, 1, 6, 8, 16, SRC_INT_RC}, '{4'he, 2'h0, 1, 258, 4, 4096, SRC_CRYSTAL},
                          '{4'he, 2'h2, 0, 1024, 4, 0, SRC_CRYSTAL}, '{4'hf, 2'h1, 1, 8, 4, 0, SRC_CRYSTAL},
                          '{4'hf, 2'h3, 1, 8, 4, 16, SRC_CRYSTAL}, '{4'hb, 2'h0, 1, 1024, 4, 16, SRC_CRYSTAL},
                          '{4'h9, 2'h2, 1, 8, 4, 16, SRC_LOW_FREQ}, '{4'h5, 2'h0, 1, 18, 4, 0, SRC_EXT_RC},
                          '{4'h0, 2'h0, 1, 6, 4, 0, SRC_EXT_CLOCK}};
  // Sleep enables as {core, program memory, peripheral, converter, async timer}
  logic [4:0]  slp_exp[4] = '{5'h07, 5'h03, 5'h00, 5'h01};

  clock_source_select_startup #(.LONG_WDT_CYCLES(16), .SRC_16K_CYCLES(8), .SRC_32K_CYCLES(8)) uut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_source_fuses(src_f),
    .startup_time_fuses(sut_f), .amplifier_option_fuse(amp_f), .osc_in_pin(osc_in), .internal_rc_osc(rc_osc),
    .watchdog_osc(wdt_osc), .wake_req(wake_req), .core_clock_en(core_en), .peripheral_clock_en(per_en),
    .program_memory_clock_en(pm_en), .converter_clock_en(cv_en), .async_timer_clock_en(at_en),
    .async_detect_en(det_en), .amp_full_swing(amp_fs), .crystal_band(band), .source_class(cls),
    .rc_calibration_register(cal), .startup_done(done));
  osc_sources osc_i (
    .osc_in_pin(osc_in), .internal_rc_osc(rc_osc), .watchdog_osc(wdt_osc));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset(input logic [3:0] f, input logic [1:0] s, input logic a, input int hold);
    @(posedge ref_clk);
    rst <= 1'b1; src_f <= f; sut_f <= s; amp_f <= a;
    repeat (hold) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task wait_core;
    n = 0;
    while (core_en !== 1'b1 && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  // Free-running sources put the first counted edge anywhere inside one period
  function automatic logic [31:0] in_win(int got, int exp, int slack);
    return 32'(got >= exp - slack && got <= exp + slack + 16);
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    err_total++;
    end_sim();
  end
  initial begin
    for (int i = 0; i < 9; i++) begin
      do_reset(tbl[i].f, tbl[i].s, tbl[i].a, i == 0 ? 16 : 4);
      wait_core();
      chk("start-up cycles", in_win(n, 2 + tbl[i].ns * tbl[i].ps + tbl[i].nw * 6, tbl[i].ps), 1);
      chk("source class", 32'(cls), 32'(tbl[i].c));
      chk("amp mode", 32'(amp_fs), 32'(!tbl[i].a));
      apb(1'b1, CTRL_OFFSET, 32'h8);
      repeat (2) @(posedge ref_clk);
      chk("async timer", 32'(at_en), 32'(tbl[i].c == SRC_INT_RC));
      $display("start-up test %0d done", i);
    end
    apb(1'b1, STORE_OFFSET, 32'h5a);
    do_reset(4'h1, 2'h0, 1'b1, 4);
    wait_core();
    chk("cal port", 32'(cal), 32'h5a);
    apb(1'b0, CAL_OFFSET, 32'h0);
    chk("cal read", rd, 32'h5a);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status", 32'(rd[9:0]), 32'h203);
    apb(1'b1, 8'h0c, 32'h5a);
    chk("unmapped error", 32'(er), 1);
    apb(1'b1, CTRL_OFFSET, 32'h8);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CTRL_OFFSET, 32'hc | m);
      repeat (3) @(posedge ref_clk);
      chk("sleep enables", 32'({core_en, pm_en, per_en, cv_en, at_en}), 32'(slp_exp[m]));
      chk("async detect", 32'(det_en), 32'(!slp_exp[m][2]));
      wake_req <= 1'b1;
      wait_core();
      wake_req <= 1'b0;
      chk("wake cycles", m < 2 ? 32'(n < 10) : in_win(n, 48, 8), 1);
      $display("sleep test %0d done", m);
    end
    end_sim();
  end
endmodule
